// *** rtl/tcr_pkg.sv ***
// Package with control byte layout, default mode values and timing for the line control register
package tcr_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned SEL0_BIT = 0;
    localparam int unsigned SEL1_BIT = 1;
    localparam int unsigned DRR_BIT = 2;
    localparam int unsigned RATE_BIT = 3;
    localparam int unsigned SIGNALLING_IN_BEARER_BIT = 4;
    localparam int unsigned SCR_BIT = 5;
    localparam int unsigned FAST_BIT = 6;
    localparam int unsigned HK_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam logic [3:0] DEFAULT_CODE = 4'hF;
    localparam logic [7:0] DEFAULT1_CTRL = 8'h00;
    localparam logic [7:0] DEFAULT2_CTRL = 8'h08;
    localparam logic [6:0] DEFAULT_DIAG = 7'h02;
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_DIAG = 2'h2;
    localparam int unsigned FAST_FRAMES_160 = 240;
    localparam int unsigned FAST_FRAMES_80 = 480;
    localparam int unsigned CONV_MS_160 = 850;
    localparam int unsigned CONV_MS_80 = 1750;
    localparam longint unsigned CONV_CYC_160 = longint'(CONV_MS_160) * (CLK_HZ / 1000);
    localparam longint unsigned CONV_CYC_80 = longint'(CONV_MS_80) * (CLK_HZ / 1000);

    typedef struct packed {
        logic diag_reset_request;
        logic bit_rate_choice;
        logic signalling_in_bearer;
        logic scrambler_enable;
        logic fast_converge;
        logic tx_housekeeping_bit;
    } tcr_ctrl_s;
endpackage

// *** rtl/tcr_diag_if.sv ***
// Interface carrying diagnostics register traffic between control decode and diagnostics holder
`timescale 1ns/10ps
interface tcr_diag_if;
    logic wr;
    logic [7:0] data;
    logic load_default;
    logic clear;
    logic [7:0] value;
    modport ctrl (output wr, output data, output load_default, output clear, input value);
    modport diag (input wr, input data, input load_default, input clear, output value);
endinterface

// *** rtl/tcr_diag_hold.sv ***
// Diagnostics register holder: written, reset on frame, or loaded with the default value
`timescale 1ns/10ps
module tcr_diag_hold (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Diagnostics traffic
    tcr_diag_if.diag dif
);
    import tcr_pkg::*;

    typedef struct packed {
        logic [7:0] val;
    } tcr_diag_s;

    tcr_diag_s st_q;
    tcr_diag_s st_d;

    always_comb begin
        st_d = st_q;
        // Default load takes priority over a pending frame reset
        if (dif.load_default) begin
            st_d.val = {1'b0, DEFAULT_DIAG};
        end else if (dif.wr) begin
            st_d.val = dif.data;
        end else if (dif.clear) begin
            st_d.val = 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dif.value = st_q.val;
endmodule

// *** rtl/tcr_line_control.sv ***
// Line transceiver control register: control byte decode, default modes, diagnostics routing
//
// Operation
// [R1] Bits 0 and 1 zero write control
// [R2] Bit0 zero, bit1 one writes diagnostics
// [R3] Bit2 zero resets diagnostics at frame
// [R4] Bit3 selects 80 or 160 kbit/s
// [R5] Bit4 moves signalling into first bearer slot
// [R6] Bit5 enables scrambler and descrambler
// [R7] Bit6 selects fast echo convergence
// [R8] System holds fast bit for early frames
// [R9] Convergence within 850 ms or 1.75 s
// [R10] Bit7 is transmitted housekeeping bit
// [R11] Bits 4-7 all one select default mode
// [R12] XXX01111 gives default mode one
// [R13] XXX11111 gives default mode two
`timescale 1ns/10ps
module tcr_line_control (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control channel
    input wire logic frame_pulse,
    input wire logic ctrl_byte_valid,
    input wire logic [7:0] ctrl_byte,
    // Control outputs
    output logic bit_rate_choice,
    output logic signalling_in_bearer,
    output logic scrambler_enable,
    output logic fast_converge,
    output logic tx_housekeeping_bit,
    output logic diag_reset_request,
    output logic [7:0] diag_value,
    output logic converge_window
);
    import tcr_pkg::*;

    localparam int unsigned CW = 32;

    // Counter must span the slower-rate window, or the window would end early
    if ((64'(CONV_CYC_80) >= (64'd1 << CW)) || (64'(CONV_CYC_160) >= (64'd1 << CW))) begin : g_cw_check
        $error("Convergence counter too narrow");
    end

    // ====================================================================
    // State
    typedef struct packed {
        tcr_ctrl_s ctrl;
        logic clr_now;
        logic [7:0] diag;
        logic [CW-1:0] conv_cnt;
        logic conv_win;
    } tcr_state_s;

    tcr_state_s st_q;
    tcr_state_s st_d;
    tcr_diag_if dif ();

    function automatic logic [1:0] sel_of(input logic [7:0] b);
        sel_of = {b[SEL1_BIT], b[SEL0_BIT]};
    endfunction

    // ====================================================================
    // Decode
    logic wr_ctrl;
    logic wr_diag;
    logic is_default;
    logic [CW-1:0] conv_lim;

    assign wr_ctrl = ctrl_byte_valid && (sel_of(ctrl_byte) == SEL_CTRL); // [R1]
    assign wr_diag = ctrl_byte_valid && (sel_of(ctrl_byte) == SEL_DIAG); // [R2]
    assign is_default = ctrl_byte[HK_BIT:SIGNALLING_IN_BEARER_BIT] == DEFAULT_CODE; // [R11]
    // Convergence window length tracks the selected rate
    assign conv_lim = st_q.ctrl.bit_rate_choice ? CW'(CONV_CYC_160) : CW'(CONV_CYC_80); // [R9]

    assign dif.wr = wr_diag;
    assign dif.data = ctrl_byte;
    assign dif.load_default = wr_ctrl && is_default; // [R12] [R13]
    assign dif.clear = st_q.clr_now;

    tcr_diag_hold u_diag (
        .core_clk(core_clk),
        .resetn(resetn),
        .dif(dif)
    );

    always_comb begin
        logic [7:0] v;
        v = ctrl_byte;
        st_d = st_q;
        st_d.clr_now = 1'b0;
        st_d.diag = dif.value;
        if (wr_ctrl) begin
            if (is_default) begin
                v = ctrl_byte[RATE_BIT] ? DEFAULT2_CTRL : DEFAULT1_CTRL; // [R12] [R13]
                v[DRR_BIT] = 1'b1;
            end
            st_d.ctrl.diag_reset_request = ~v[DRR_BIT]; // [R3]
            st_d.ctrl.bit_rate_choice = v[RATE_BIT]; // [R4]
            st_d.ctrl.signalling_in_bearer = v[SIGNALLING_IN_BEARER_BIT]; // [R5]
            st_d.ctrl.scrambler_enable = v[SCR_BIT]; // [R6]
            st_d.ctrl.fast_converge = v[FAST_BIT]; // [R7] [R8]
            st_d.ctrl.tx_housekeeping_bit = v[HK_BIT]; // [R10]
        end
        // Reset lands on the frame pulse; a write in that cycle leaves the request at the written value
        if (frame_pulse && st_q.ctrl.diag_reset_request) begin
            st_d.clr_now = 1'b1; // [R3]
            if (!wr_ctrl) begin
                st_d.ctrl.diag_reset_request = 1'b0;
            end
        end
        // Window counts from the last fast-convergence release
        if (st_q.ctrl.fast_converge) begin
            st_d.conv_cnt = '0;
            st_d.conv_win = 1'b1;
        end else if (st_q.conv_win) begin
            if (st_q.conv_cnt >= conv_lim) begin
                st_d.conv_win = 1'b0; // [R9]
            end else begin
                st_d.conv_cnt = st_q.conv_cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{ctrl: '{diag_reset_request: 1'b0, bit_rate_choice: 1'b0, signalling_in_bearer: 1'b0,
                      scrambler_enable: 1'b0, fast_converge: 1'b0, tx_housekeeping_bit: 1'b0},
                      clr_now: 1'b0, diag: 8'h00, conv_cnt: '0, conv_win: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign bit_rate_choice = st_q.ctrl.bit_rate_choice;
    assign signalling_in_bearer = st_q.ctrl.signalling_in_bearer;
    assign scrambler_enable = st_q.ctrl.scrambler_enable;
    assign fast_converge = st_q.ctrl.fast_converge;
    assign tx_housekeeping_bit = st_q.ctrl.tx_housekeeping_bit;
    assign diag_reset_request = st_q.ctrl.diag_reset_request;
    assign diag_value = st_q.diag;
    assign converge_window = st_q.conv_win;
endmodule

// *** tb/tcr_line_control_assertions.sv ***
// Checker for the line control register ports
`timescale 1ns/10ps
module tcr_chk import tcr_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control channel
    input wire logic frame_pulse,
    input wire logic ctrl_byte_valid,
    input wire logic [7:0] ctrl_byte,
    // Control outputs
    input wire logic bit_rate_choice,
    input wire logic signalling_in_bearer,
    input wire logic scrambler_enable,
    input wire logic fast_converge,
    input wire logic tx_housekeeping_bit,
    input wire logic diag_reset_request,
    input wire logic [7:0] diag_value,
    input wire logic converge_window
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic [4:0] outs = {bit_rate_choice, signalling_in_bearer, scrambler_enable, fast_converge,
        tx_housekeeping_bit};
    sequence s_ctrl;
        ctrl_byte_valid && ctrl_byte[1:0] == SEL_CTRL && ctrl_byte[7:4] != DEFAULT_CODE;
    endsequence
    sequence s_dflt;
        ctrl_byte_valid && ctrl_byte[1:0] == SEL_CTRL && ctrl_byte[7:4] == DEFAULT_CODE;
    endsequence
    // Clear lands two edges after the frame unless a byte follows straight after
    sequence s_frame_clr;
        diag_reset_request && frame_pulse && !ctrl_byte_valid ##1 !ctrl_byte_valid;
    endsequence
    AST_IGNORE: assert property (ctrl_byte_valid && ctrl_byte[0] |=> $stable(outs)) else $error("ignored");
    AST_RATE: assert property (s_ctrl |=> bit_rate_choice == $past(ctrl_byte[3])) else $error("rate");
    AST_SIGNALLING_IN_BEARER: assert property (s_ctrl |=> signalling_in_bearer == $past(ctrl_byte[4])) else $error("signalling_in_bearer");
    AST_SCR: assert property (s_ctrl |=> scrambler_enable == $past(ctrl_byte[5])) else $error("scr");
    AST_FAST: assert property (s_ctrl |=> fast_converge == $past(ctrl_byte[6])) else $error("fast");
    AST_HK: assert property (s_ctrl |=> tx_housekeeping_bit == $past(ctrl_byte[7])) else $error("hk");
    AST_DRR_SET: assert property (s_ctrl ##0 !ctrl_byte[2] |=> diag_reset_request) else $error("drr");
    AST_FRAME: assert property (s_frame_clr |-> !diag_reset_request ##2 diag_value == 8'h00)
        else $error("frame");
    AST_DIAG: assert property (ctrl_byte_valid && ctrl_byte[1:0] == SEL_DIAG
        |-> ##2 diag_value == $past(ctrl_byte, 2)) else $error("diag");
    AST_DFLT: assert property (s_dflt |=> outs == {$past(ctrl_byte[3]), 4'h0}
        && !diag_reset_request ##1 diag_value == {1'b0, DEFAULT_DIAG}) else $error("default");
    AST_WIN: assert property (fast_converge |=> converge_window) else $error("window");
    AST_WIN_IDLE: assert property (!fast_converge && !converge_window |=> !converge_window)
        else $error("window idle");
endmodule
bind tcr_line_control tcr_chk i_chk (
    .core_clk(core_clk),
    .resetn(resetn),
    .frame_pulse(frame_pulse),
    .ctrl_byte_valid(ctrl_byte_valid),
    .ctrl_byte(ctrl_byte),
    .bit_rate_choice(bit_rate_choice),
    .signalling_in_bearer(signalling_in_bearer),
    .scrambler_enable(scrambler_enable),
    .fast_converge(fast_converge),
    .tx_housekeeping_bit(tx_housekeeping_bit),
    .diag_reset_request(diag_reset_request),
    .diag_value(diag_value),
    .converge_window(converge_window)
);

// *** tb/tcr_sys_model.sv ***
// System controller model driving control bytes and frame pulses
`timescale 1ns/10ps
module tcr_sys_model (
    // Clock
    input wire logic core_clk,
    // Control channel
    output logic frame_pulse,
    output logic ctrl_byte_valid,
    output logic [7:0] ctrl_byte
);
    initial begin
        frame_pulse = 1'b0;
        ctrl_byte_valid = 1'b0;
        ctrl_byte = 8'h00;
    end
    // Released byte is inverted so a stale value never looks live
    task automatic send(input logic [7:0] b);
        @(negedge core_clk);
        ctrl_byte_valid = 1'b1;
        ctrl_byte = b;
        @(negedge core_clk);
        ctrl_byte_valid = 1'b0;
        ctrl_byte = ~b;
    endtask
    task automatic frame();
        @(negedge core_clk);
        frame_pulse = 1'b1;
        @(negedge core_clk);
        frame_pulse = 1'b0;
    endtask
    // Shortened start-up: fast bit held for a few frames, then cleared
    task automatic start_up(input int n);
        send(8'h44);
        repeat (n) frame();
        send(8'h04);
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the line control register
`timescale 1ns/10ps
module tb;
    import tcr_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic frame_pulse, ctrl_byte_valid, converge_window;
    logic bit_rate_choice, signalling_in_bearer, scrambler_enable, fast_converge, tx_housekeeping_bit;
    logic diag_reset_request;
    logic [7:0] ctrl_byte, diag_value, b;
    logic [5:0] outs;
    int bad_count = 0;
    int compares = 0;
    assign outs = {bit_rate_choice, signalling_in_bearer, scrambler_enable, fast_converge, tx_housekeeping_bit,
        diag_reset_request};
    always #2 core_clk = ~core_clk;
    tcr_sys_model i_sys (
        .core_clk(core_clk),
        .frame_pulse(frame_pulse),
        .ctrl_byte_valid(ctrl_byte_valid),
        .ctrl_byte(ctrl_byte)
    );
    tcr_line_control i_dut (
        .core_clk(core_clk),
        .resetn(resetn),
        .frame_pulse(frame_pulse),
        .ctrl_byte_valid(ctrl_byte_valid),
        .ctrl_byte(ctrl_byte),
        .bit_rate_choice(bit_rate_choice),
        .signalling_in_bearer(signalling_in_bearer),
        .scrambler_enable(scrambler_enable),
        .fast_converge(fast_converge),
        .tx_housekeeping_bit(tx_housekeeping_bit),
        .diag_reset_request(diag_reset_request),
        .diag_value(diag_value),
        .converge_window(converge_window)
    );
    function automatic logic [7:0] exp_of(input logic [7:0] v);
        return {2'h0, v[3], v[4], v[5], v[6], v[7], ~v[2]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] v, input logic [7:0] e, input logic [7:0] d);
        i_sys.send(v);
        check({2'h0, outs}, e);
        @(negedge core_clk);
        check(diag_value, d);
    endtask
    task automatic close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        check({2'h0, outs}, 8'h00);
        check({7'h0, converge_window}, 8'h00);
        resetn = 1'b1;
        wr(8'h4A, 8'h00, 8'h4A);
        for (int i = 3; i < 8; i++) begin
            b = 8'h04 | (8'h01 << i);
            wr(b, exp_of(b), 8'h4A);
        end
        wr(8'hF9, exp_of(8'h84), 8'h4A);
        wr(8'h60, exp_of(8'h60), 8'h4A);
        i_sys.frame();
        check({2'h0, outs}, exp_of(8'h64));
        // Clear reaches the diagnostics output two edges after the frame edge
        repeat (2) @(negedge core_clk);
        check(diag_value, 8'h00);
        wr(8'h4A, exp_of(8'h64), 8'h4A);
        wr(8'h24, exp_of(8'h24), 8'h4A);
        i_sys.frame();
        repeat (2) @(negedge core_clk);
        check(diag_value, 8'h4A);
        wr(8'hF4, 8'h00, {1'b0, DEFAULT_DIAG});
        wr(8'hFC, 8'h20, {1'b0, DEFAULT_DIAG});
        i_sys.start_up(4);
        check({2'h0, outs}, 8'h00);
        check({7'h0, converge_window}, 8'h01);
        close_out();
    end
    initial begin
        #10000;
        bad_count++;
        close_out();
    end
endmodule
